// ---- rtl/can_stamp_pkg.sv ----
// Purpose: Shared constants and types for the stamp control and message data block
// Assumes: AXI4-Lite with 32-bit data, one register per aligned word
// Notes:   Stamp control index is kept as printed; its byte address is four times it

package can_stamp_pkg;

  // ******************************
  // Register map
  // ******************************
  localparam logic [31:0] STAMP_CTRL_INDEX = 32'h0000_FF8A;
  localparam logic [31:0] STAMP_CTRL_ADDR  = STAMP_CTRL_INDEX << 2;
  localparam logic [31:0] DATA_BASE        = 32'h0000_1000;
  localparam int          DATA_REGION_LSB  = 12;
  localparam int          BUF_STRIDE_LSB   = 6;
  localparam logic [3:0]  PAIR_SLOT_FIRST  = 4'h8;
  localparam logic [3:0]  PAIR_SLOT_LAST   = 4'hB;

  // ******************************
  // Stamp control fields
  // ******************************
  localparam int          STAMP_EN_POS     = 0;
  localparam int          STAMP_SEL_POS    = 1;
  localparam int          STAMP_LOCK_POS   = 2;
  localparam int          STAMP_SET_LSB    = 8;
  localparam int          STAMP_BITS       = 3;
  localparam logic [2:0]  STAMP_CTRL_RESET = 3'h0;

  // ******************************
  // Bus answers
  // ******************************
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef enum logic [1:0] {
    REG_NONE,
    REG_STAMP,
    REG_BYTE,
    REG_PAIR
  } reg_kind_e;

  typedef enum logic {
    WR_COLLECT,
    WR_RESP
  } wr_state_e;

  typedef enum logic {
    RD_IDLE,
    RD_RESP
  } rd_state_e;

endpackage

// ---- rtl/can_timestamp_and_msg_data.sv ----
// Purpose: Time stamp toggle control and per-buffer message data bytes behind AXI4-Lite
// Assumes: Protocol engine pulses and receive writes are synchronous to aclk
// Notes:   Data bytes are not reset; their contents are undefined until written

`timescale 1ns/1ns

// Contract
// - The stamp control bits are all zero after reset.
// - Writing set bit n+8 as 1 with clear bit n as 0 sets control bit n (lock 2, select 1, enable 0).
// - Writing set bit 0 with clear bit 1 clears the corresponding control bit.
// - Writing both set and clear as 0, or both as 1, leaves the control bit unchanged.
// - With toggle enable at 1 the stamp output inverts on each selected event without a same-cycle lock, otherwise it holds.
// - Select 0 picks the start-of-frame bit as event, select 1 the last end-of-frame bit.
// - With lock enable at 0 the output keeps toggling on every selected event.
// - With lock enable at 1 the output freezes once a data frame is received into buffer 0.
// - On that lock hardware clears the toggle enable bit to 0.
// - Each message buffer holds eight byte registers, indexed 0 to 7, with the frame payload.
// - Four 16-bit pair registers reach byte pairs 01, 23, 45 and 67 of each buffer.
// - The data bytes are not initialised by reset and read undefined until written.
module can_timestamp_and_msg_data #(
  parameter int NUM_BUF = 16,
  parameter int BUF_W   = (NUM_BUF > 1) ? $clog2(NUM_BUF) : 1
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // AXI4-Lite write address
  input  wire logic [31:0]      s_axi_awaddr,
  input  wire logic [2:0]       s_axi_awprot,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0]      s_axi_araddr,
  input  wire logic [2:0]       s_axi_arprot,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Protocol engine events
  input  wire logic             sof_event,
  input  wire logic             eof_last_event,
  input  wire logic             rx_frame_ok,
  input  wire logic [BUF_W-1:0] rx_frame_buf,
  // Protocol engine payload write
  input  wire logic             rx_wr_en,
  input  wire logic [BUF_W-1:0] rx_wr_buf,
  input  wire logic [2:0]       rx_wr_idx,
  input  wire logic [7:0]       rx_wr_byte,
  // Protocol engine payload read
  input  wire logic [BUF_W-1:0] tx_rd_buf,
  input  wire logic [2:0]       tx_rd_idx,
  output logic [7:0]            tx_rd_byte,
  // Timer side
  output logic                  stamp_toggle_out
);

  // ******************************
  // Types and state
  // ******************************
  localparam int MEM_W = BUF_W + 3;

  typedef struct packed {
    can_stamp_pkg::reg_kind_e kind;
    logic [BUF_W-1:0]         buf_num;
    logic [2:0]               idx;
  } decode_s;

  typedef struct packed {
    can_stamp_pkg::wr_state_e wr_state;
    logic                     aw_full;
    logic                     w_full;
    logic [31:0]              awaddr;
    logic [31:0]              wdata;
    logic [3:0]               wstrb;
    logic                     awready;
    logic                     wready;
    logic                     bvalid;
    logic [1:0]               bresp;
    can_stamp_pkg::rd_state_e rd_state;
    logic                     arready;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
    logic [2:0]               ctrl;
    logic                     toggle_out;
    logic [7:0]               tx_byte;
  } state_s;

  state_s s_reg;
  state_s s_next;

  // Payload store, deliberately without reset
  logic [7:0] msg_data_byte_reg [NUM_BUF*8];

  logic             we_lo;
  logic             we_hi;
  logic [MEM_W-1:0] waddr_lo;
  logic [MEM_W-1:0] waddr_hi;
  logic [7:0]       wbyte_lo;
  logic [7:0]       wbyte_hi;

  // ******************************
  // Address decode
  // ******************************
  function automatic decode_s decode(input logic [31:0] addr);
    decode_s    d;
    logic [3:0] slot;
    d.kind    = can_stamp_pkg::REG_NONE;
    d.buf_num = addr[can_stamp_pkg::BUF_STRIDE_LSB +: BUF_W];
    d.idx     = addr[4:2];
    slot      = addr[5:2];
    if (addr == can_stamp_pkg::STAMP_CTRL_ADDR) begin
      d.kind = can_stamp_pkg::REG_STAMP;
    end else if (addr[31:can_stamp_pkg::DATA_REGION_LSB] ==
                 can_stamp_pkg::DATA_BASE[31:can_stamp_pkg::DATA_REGION_LSB]
                 && addr[1:0] == 2'h0
                 && addr[can_stamp_pkg::DATA_REGION_LSB-1:can_stamp_pkg::BUF_STRIDE_LSB] < NUM_BUF) begin
      if (slot < can_stamp_pkg::PAIR_SLOT_FIRST) begin
        d.kind = can_stamp_pkg::REG_BYTE;
      end else if (slot <= can_stamp_pkg::PAIR_SLOT_LAST) begin
        d.kind = can_stamp_pkg::REG_PAIR;
        d.idx  = {slot[1:0], 1'b0};
      end
    end
    return d;
  endfunction

  // ******************************
  // Set and clear pairs
  // ******************************
  // Each control bit moves only when exactly one of its set and clear bits is 1
  // Writing both, or neither, leaves the bit alone, so a lane of zeros is harmless
  function automatic logic [can_stamp_pkg::STAMP_BITS-1:0] apply_set_clear(
    input logic [can_stamp_pkg::STAMP_BITS-1:0] cur,
    input logic [can_stamp_pkg::STAMP_BITS-1:0] set_w,
    input logic [can_stamp_pkg::STAMP_BITS-1:0] clr_w
  );
    logic [can_stamp_pkg::STAMP_BITS-1:0] res;
    res = cur;
    for (int n = 0; n < can_stamp_pkg::STAMP_BITS; n++) begin
      if (set_w[n] && !clr_w[n]) begin
        res[n] = 1'b1;
      end else if (clr_w[n] && !set_w[n]) begin
        res[n] = 1'b0;
      end
    end
    return res;
  endfunction

  // ******************************
  // Next state
  // ******************************
  always_comb begin
    decode_s    dw;
    decode_s    dr;
    logic [2:0] set_bits;
    logic [2:0] clr_bits;
    logic       cap_event;
    logic       lock_hit;
    cap_event = 1'b0;
    lock_hit  = 1'b0;
    s_next   = s_reg;
    we_lo    = 1'b0;
    we_hi    = 1'b0;
    waddr_lo = '0;
    waddr_hi = '0;
    wbyte_lo = 8'h00;
    wbyte_hi = 8'h00;
    dw       = decode(s_reg.awaddr);
    dr       = decode(s_axi_araddr);
    set_bits = s_reg.wdata[can_stamp_pkg::STAMP_SET_LSB +: can_stamp_pkg::STAMP_BITS]
               & {3{s_reg.wstrb[1]}};
    clr_bits = s_reg.wdata[can_stamp_pkg::STAMP_BITS-1:0] & {3{s_reg.wstrb[0]}};

    // Receive path owns the store port; a pending bus write waits while rx_wr_en is high
    if (rx_wr_en) begin
      we_lo    = 1'b1;
      waddr_lo = {rx_wr_buf, rx_wr_idx};
      wbyte_lo = rx_wr_byte;
    end

    // ******************************
    // Write channels
    // ******************************
    // Address and data are taken in either order and held until both are in
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_full = 1'b1;
      s_next.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_full = 1'b1;
      s_next.wdata  = s_axi_wdata;
      s_next.wstrb  = s_axi_wstrb;
    end

    unique case (s_reg.wr_state)
      can_stamp_pkg::WR_COLLECT: begin
        if (s_reg.aw_full && s_reg.w_full && !rx_wr_en) begin
          s_next.aw_full  = 1'b0;
          s_next.w_full   = 1'b0;
          s_next.bvalid   = 1'b1;
          s_next.bresp    = can_stamp_pkg::RESP_OKAY;
          s_next.wr_state = can_stamp_pkg::WR_RESP;
          unique case (dw.kind)
            can_stamp_pkg::REG_STAMP: begin
              s_next.ctrl = apply_set_clear(s_reg.ctrl, set_bits, clr_bits);
            end
            can_stamp_pkg::REG_BYTE: begin
              we_lo    = s_reg.wstrb[0];
              waddr_lo = {dw.buf_num, dw.idx};
              wbyte_lo = s_reg.wdata[7:0];
            end
            can_stamp_pkg::REG_PAIR: begin
              we_lo    = s_reg.wstrb[0];
              waddr_lo = {dw.buf_num, dw.idx};
              wbyte_lo = s_reg.wdata[7:0];
              we_hi    = s_reg.wstrb[1];
              waddr_hi = {dw.buf_num, dw.idx | 3'h1};
              wbyte_hi = s_reg.wdata[15:8];
            end
            can_stamp_pkg::REG_NONE: begin
              s_next.bresp = can_stamp_pkg::RESP_SLVERR;
            end
          endcase
        end
      end
      can_stamp_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          s_next.bvalid   = 1'b0;
          s_next.wr_state = can_stamp_pkg::WR_COLLECT;
        end
      end
    endcase
    // Ready stays low through the response so a second write cannot overtake it
    s_next.awready = !s_next.aw_full && s_next.wr_state == can_stamp_pkg::WR_COLLECT;
    s_next.wready  = !s_next.w_full && s_next.wr_state == can_stamp_pkg::WR_COLLECT;

    // ******************************
    // Read channel
    // ******************************
    // Data are captured when the address is taken, so a later store write cannot tear them
    unique case (s_reg.rd_state)
      can_stamp_pkg::RD_IDLE: begin
        if (s_axi_arvalid && s_reg.arready) begin
          s_next.rvalid   = 1'b1;
          s_next.rd_state = can_stamp_pkg::RD_RESP;
          s_next.rdata    = 32'h0000_0000;
          s_next.rresp    = can_stamp_pkg::RESP_OKAY;
          unique case (dr.kind)
            can_stamp_pkg::REG_STAMP: begin
              s_next.rdata[can_stamp_pkg::STAMP_BITS-1:0] = s_reg.ctrl;
            end
            can_stamp_pkg::REG_BYTE: begin
              s_next.rdata[7:0] = msg_data_byte_reg[{dr.buf_num, dr.idx}];
            end
            can_stamp_pkg::REG_PAIR: begin
              s_next.rdata[7:0]  = msg_data_byte_reg[{dr.buf_num, dr.idx}];
              s_next.rdata[15:8] = msg_data_byte_reg[{dr.buf_num, dr.idx | 3'h1}];
            end
            can_stamp_pkg::REG_NONE: begin
              s_next.rresp = can_stamp_pkg::RESP_SLVERR;
            end
          endcase
        end
      end
      can_stamp_pkg::RD_RESP: begin
        if (s_axi_rready) begin
          s_next.rvalid   = 1'b0;
          s_next.rd_state = can_stamp_pkg::RD_IDLE;
        end
      end
    endcase
    // Only one read is in flight; the next address waits until the answer is taken
    s_next.arready = s_next.rd_state == can_stamp_pkg::RD_IDLE;

    // ******************************
    // Time stamp toggle
    // ******************************
    cap_event = s_reg.ctrl[can_stamp_pkg::STAMP_SEL_POS] ? eof_last_event : sof_event;
    lock_hit  = s_reg.ctrl[can_stamp_pkg::STAMP_LOCK_POS] && rx_frame_ok
                && rx_frame_buf == '0;
    if (lock_hit) begin
      // Lock beats a same-cycle event and a same-cycle software enable
      s_next.ctrl[can_stamp_pkg::STAMP_EN_POS] = 1'b0;
    end else if (s_reg.ctrl[can_stamp_pkg::STAMP_EN_POS] && cap_event) begin
      s_next.toggle_out = !s_reg.toggle_out;
    end

    // Transmit side sees its byte one cycle after it names it
    s_next.tx_byte = msg_data_byte_reg[{tx_rd_buf, tx_rd_idx}];
  end

  // ******************************
  // Registers
  // ******************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Bus state and control clear; the payload store keeps whatever it held
      s_reg      <= '0;
      s_reg.ctrl <= can_stamp_pkg::STAMP_CTRL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Store has no reset so it maps onto plain RAM
  always_ff @(posedge aclk) begin
    if (we_lo) begin
      msg_data_byte_reg[waddr_lo] <= wbyte_lo;
    end
    if (we_hi) begin
      msg_data_byte_reg[waddr_hi] <= wbyte_hi;
    end
  end

  // ******************************
  // Outputs
  // ******************************
  assign s_axi_awready    = s_reg.awready;
  assign s_axi_wready     = s_reg.wready;
  assign s_axi_bvalid     = s_reg.bvalid;
  assign s_axi_bresp      = s_reg.bresp;
  assign s_axi_arready    = s_reg.arready;
  assign s_axi_rvalid     = s_reg.rvalid;
  assign s_axi_rdata      = s_reg.rdata;
  assign s_axi_rresp      = s_reg.rresp;
  assign stamp_toggle_out = s_reg.toggle_out;
  assign tx_rd_byte       = s_reg.tx_byte;

endmodule

// ---- test/can_ts_assertions.sv ----
// Purpose: Port checks for the stamp toggle and the register bus handshakes
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Sees only ports of the block; bound at the foot
`timescale 1ns/1ns
module can_ts_assertions #(
  parameter int BUF_W = 4
) (
  // Clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // Bus handshakes
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  // Frame events and timer output
  input wire logic             sof_event,
  input wire logic             eof_last_event,
  input wire logic             rx_frame_ok,
  input wire logic [BUF_W-1:0] rx_frame_buf,
  input wire logic             stamp_toggle_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ******************************
  // Properties
  // ******************************
  property p_reset_zero; $rose(aresetn) |-> !stamp_toggle_out; endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("toggle high after reset");
  // Events are single pulses, so any flip needs a pulse one edge before
  property p_toggle_cause; $changed(stamp_toggle_out) |-> $past(sof_event) || $past(eof_last_event); endproperty
  a_toggle_cause: assert property (p_toggle_cause) else $error("toggle without event");
  property p_ar_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("read answer late");
  property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready; endproperty
  a_r_done: assert property (p_r_done) else $error("read not closed");
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 s_axi_awready; endproperty
  a_b_done: assert property (p_b_done) else $error("write not closed");
  property p_aw_busy; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("address taken during response");
  property p_w_busy; s_axi_bvalid |-> !s_axi_wready; endproperty
  a_w_busy: assert property (p_w_busy) else $error("data taken during response");
  property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read taken during answer");
  c_toggle: cover property ($changed(stamp_toggle_out));
  c_lock_frame: cover property (rx_frame_ok && rx_frame_buf == '0);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind can_timestamp_and_msg_data can_ts_assertions #(.BUF_W(BUF_W)) can_ts_assertions_inst (
  .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .sof_event, .eof_last_event, .rx_frame_ok,
  .rx_frame_buf, .stamp_toggle_out);

// ---- test/can_ts_engine_model.sv ----
// Purpose: Protocol engine stand-in that raises frame event pulses
// Assumes: Pulses last one cycle and are launched after a clock edge
// Notes:   Buffer number is scrambled outside a pulse so a stale value is never trusted
`timescale 1ns/1ns
module can_ts_engine_model #(
  parameter int BUF_W = 4
) (
  // Clock
  input  wire logic        aclk,
  // Frame events
  output logic             sof_event,
  output logic             eof_last_event,
  output logic             rx_frame_ok,
  output logic [BUF_W-1:0] rx_frame_buf
);
  initial begin
    sof_event = 1'b0;
    eof_last_event = 1'b0;
    rx_frame_ok = 1'b0;
    rx_frame_buf = '1;
  end
  // Kind 0 start of frame, 1 last end-of-frame bit, 2 frame stored in buffer b
  task automatic pulse(input int k, input logic [BUF_W-1:0] b);
    @(posedge aclk);
    sof_event <= (k == 0);
    eof_last_event <= (k == 1);
    rx_frame_ok <= (k == 2);
    rx_frame_buf <= b;
    @(posedge aclk);
    sof_event <= 1'b0;
    eof_last_event <= 1'b0;
    rx_frame_ok <= 1'b0;
    rx_frame_buf <= ~b;
    repeat (2) @(posedge aclk);
  endtask
endmodule

// ---- test/can_timestamp_and_msg_data_tb_top.sv ----
// Purpose: Self-checking bench for stamp control and message data bytes
// Assumes: Bus answers are compared by a monitor against queued notes
// Notes:   Stamp output compared after each event pulse has landed
`timescale 1ns/1ns
module can_timestamp_and_msg_data_tb_top;
  localparam int          NB      = 16;
  localparam logic [1:0]  OKAY    = can_stamp_pkg::RESP_OKAY;
  localparam logic [31:0] STAMP_A = can_stamp_pkg::STAMP_CTRL_ADDR;
  logic        aclk = 1'b0, aresetn = 1'b0, ts, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, rx_wr_en = 1'b0, s_axi_rvalid, stamp_toggle_out;
  logic        sof_event, eof_last_event, rx_frame_ok;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, d;
  logic [31:0] seed = 32'h0000_0f0b;
  logic [3:0]  s_axi_wstrb = 4'hf, rx_wr_buf = '0, tx_rd_buf = '0, rx_frame_buf;
  logic [2:0]  rx_wr_idx = '0, tx_rd_idx = '0, ctrl = '0;
  logic [7:0]  rx_wr_byte = '0, tx_rd_byte, b [8];
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [33:0] rq [$], bq [$];
  int          bad_count = 0, checked = 0, cycles = 0;
  can_timestamp_and_msg_data #(.NUM_BUF(NB)) can_timestamp_and_msg_data_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sof_event, .eof_last_event, .rx_frame_ok, .rx_frame_buf,
    .rx_wr_en, .rx_wr_buf, .rx_wr_idx, .rx_wr_byte, .tx_rd_buf, .tx_rd_idx, .tx_rd_byte,
    .stamp_toggle_out);
  can_ts_engine_model #(.BUF_W(4)) can_ts_engine_model_inst (
    .aclk, .sof_event, .eof_last_event, .rx_frame_ok, .rx_frame_buf);
  initial forever #5 aclk = ~aclk;
  // ******************************
  // Helpers
  // ******************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [2:0] upd(input logic [2:0] c, input logic [31:0] w);
    for (int n = 0; n < 3; n++) if (w[n+8] != w[n]) c[n] = w[n+8];
    return c;
  endfunction
  function automatic logic [33:0] okv(input logic [31:0] v);
    return {OKAY, v};
  endfunction
  function automatic logic [31:0] dadr(input int m, input int off);
    return can_stamp_pkg::DATA_BASE + 32'(m * 64 + off);
  endfunction
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r);
    bq.push_back(34'(r));
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic ev(input int k, input logic [3:0] fb, input logic flip);
    can_ts_engine_model_inst.pulse(k, fb);
    ts = ts ^ flip;
    chk("stamp_toggle_out", 34'(ts), 34'(stamp_toggle_out));
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ******************************
  // Monitor and timeout
  // ******************************
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (s_axi_rvalid && s_axi_rready) chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) chk("bresp", bq.pop_front(), 34'(s_axi_bresp));
    if (cycles == 8000) begin
      bad_count++;
      end_of_test();
    end
  end
  // ******************************
  // Scenarios
  // ******************************
  initial begin
    ts = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(STAMP_A, okv(32'h0000_0000));
    for (int i = 0; i < 24; i++) begin
      d = rnd();
      ctrl = upd(ctrl, d);
      wr(STAMP_A, d, OKAY);
      rd(STAMP_A, okv(32'(ctrl)));
    end
    wr(STAMP_A, 32'h0000_0106, OKAY);
    ev(0, 4'h1, 1'b1);
    ev(1, 4'h1, 1'b0);
    ev(2, 4'h0, 1'b0);
    ev(0, 4'h1, 1'b1);
    wr(STAMP_A, 32'h0000_0200, OKAY);
    ev(1, 4'h1, 1'b1);
    ev(0, 4'h1, 1'b0);
    wr(STAMP_A, 32'h0000_0001, OKAY);
    ev(1, 4'h1, 1'b0);
    wr(STAMP_A, 32'h0000_0500, OKAY);
    ev(2, 4'h3, 1'b0);
    ev(1, 4'h1, 1'b1);
    ev(2, 4'h0, 1'b0);
    rd(STAMP_A, okv(32'h0000_0006));
    ev(1, 4'h1, 1'b0);
    // Re-enable so the output is high when reset strikes mid-run
    wr(STAMP_A, 32'h0000_0100, OKAY);
    ev(1, 4'h1, 1'b1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    ts = 1'b0;
    @(posedge aclk);
    chk("stamp_toggle_out", 34'(ts), 34'(stamp_toggle_out));
    rd(STAMP_A, okv(32'h0000_0000));
    // A lane that is not strobed counts as zeros
    s_axi_wstrb <= 4'h2;
    wr(STAMP_A, 32'h0000_0707, OKAY);
    rd(STAMP_A, okv(32'h0000_0007));
    s_axi_wstrb <= 4'h1;
    wr(STAMP_A, 32'h0000_0702, OKAY);
    rd(STAMP_A, okv(32'h0000_0005));
    s_axi_wstrb <= 4'hf;
    for (int m = 0; m < NB; m += NB - 1) begin
      for (int x = 0; x < 8; x++) begin
        d = rnd();
        b[x] = d[7:0];
        wr(dadr(m, 4 * x), d, OKAY);
      end
      for (int z = 0; z < 4; z++) rd(dadr(m, 32 + 4 * z), okv({16'h0000, b[2*z+1], b[2*z]}));
      d = rnd();
      wr(dadr(m, 36), d, OKAY);
      rd(dadr(m, 8), okv(32'(d[7:0])));
      rd(dadr(m, 12), okv(32'(d[15:8])));
    end
    wr(dadr(0, 48), 32'hffff_ffff, can_stamp_pkg::RESP_SLVERR);
    rd(dadr(0, 48), {can_stamp_pkg::RESP_SLVERR, 32'h0000_0000});
    d = rnd();
    rx_wr_buf <= 4'h2;
    rx_wr_idx <= 3'h5;
    rx_wr_byte <= d[7:0];
    rx_wr_en <= 1'b1;
    @(posedge aclk);
    rx_wr_en <= 1'b0;
    tx_rd_buf <= 4'h2;
    tx_rd_idx <= 3'h5;
    repeat (2) @(posedge aclk);
    chk("tx_rd_byte", 34'(d[7:0]), 34'(tx_rd_byte));
    rd(dadr(2, 20), okv(32'(d[7:0])));
    end_of_test();
  end
endmodule
